// ---- design/spc_defines.svh ----
// Constants of the parameter channel: lengths, register map, fields and codes.
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
`define LEN_FIXED3 7'h03
`define LEN_FIXED4 7'h04
`define LEN_VARIABLE 7'h7F
`define MAX_VALUES_PZD 7'h76
`define MAX_VALUES_NOPZD 7'h7E
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_DWORD_MASK 8'h08
`define REG_ARRAY_MASK 8'h0C
`define REG_MEM_ADDR 8'h10
`define REG_MEM_DATA 8'h14
`define REG_TASK_COUNT 8'h18
`define CTRL_AUTH_BIT 8
`define CTRL_AUTH_RESET 1'b1
`define TOGGLE_BIT 11
`define TEXT_FLAG_BIT 15
`define INDEX_ALL 8'hFF
`define TASK_NONE 4'h0
`define TASK_READ 4'h1
`define TASK_W_RAM 4'h2
`define TASK_DW_RAM 4'h3
`define TASK_DESC_RD 4'h4
`define TASK_DESC_WR 4'h5
`define TASK_ARR_RD 4'h6
`define TASK_ARR_W_RAM 4'h7
`define TASK_ARR_DW_RAM 4'h8
`define TASK_ARR_COUNT 4'h9
`define TASK_RESERVED 4'hA
`define TASK_ARR_DW_NV 4'hB
`define TASK_ARR_W_NV 4'hC
`define TASK_DW_NV 4'hD
`define TASK_W_NV 4'hE
`define TASK_TEXT 4'hF
`define REPLY_NONE 4'h0
`define REPLY_WORD 4'h1
`define REPLY_DWORD 4'h2
`define REPLY_DESC 4'h3
`define REPLY_ARR_WORD 4'h4
`define REPLY_ARR_DWORD 4'h5
`define REPLY_COUNT 4'h6
`define REPLY_FAIL 4'h7
`define REPLY_NO_AUTH 4'h8
`define FAULT_PNU 8'h00
`define FAULT_SUBINDEX 8'h03
`define FAULT_NO_ARRAY 8'h04
`define FAULT_TYPE 8'h05
`define FAULT_DESC_RO 8'h07
`define FAULT_NO_TEXT 8'h0F
`define FAULT_STATE 8'h11
`endif

// ---- design/spc_pkg.sv ----
// Types shared by the parameter channel modules.
package spc_pkg;
  typedef logic [15:0] word_t;
  typedef logic [3:0] code_t;
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_SEND = 1'b1
  } exec_state_t;
endpackage : spc_pkg

// ---- design/spc_chan_if.sv ----
// Request and reply signals between receiver, executor and sender.
interface spc_chan_if;
  logic req_valid;
  logic req_ready;
  spc_pkg::word_t req_ident;
  spc_pkg::word_t req_index;
  logic [31:0] req_value;
  logic [2:0] req_nwords;
  logic rsp_start;
  logic [6:0] rsp_len;
  logic [6:0] rsp_idx;
  spc_pkg::word_t rsp_word;
  logic rsp_done;
  modport rx (output req_valid, req_ident, req_index, req_value, req_nwords, input req_ready);
  modport exec (input req_valid, req_ident, req_index, req_value, req_nwords, rsp_idx, rsp_done,
                output req_ready, rsp_start, rsp_len, rsp_word);
  modport tx (input rsp_start, rsp_len, rsp_word, output rsp_idx, rsp_done);
endinterface : spc_chan_if

// ---- design/param_word_rx.sv ----
// Collects incoming channel words into one request.
`include "spc_defines.svh"
module param_word_rx (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire spc_pkg::word_t rx_word,
  output logic rx_ready,
  input wire logic [6:0] len_setting,
  spc_chan_if.rx chan
);
  import spc_pkg::*;
  typedef struct packed {
    logic [2:0] cnt;
    logic [3:0][15:0] w;
    logic pend;
    logic [2:0] nw;
  } rx_state_t;
  rx_state_t r, n;

  always_comb begin
    logic [2:0] k;
    logic last;
    n = r;
    k = rx_first ? 3'h0 : r.cnt;
    last = 1'b0;
    if (r.pend && chan.req_ready) begin
      n.pend = 1'b0;
    end
    if (rx_valid && !r.pend && k != 3'h7) begin
      if (rx_first) begin
        n.w = '0;
      end
      if (k < 3'h4) begin
        n.w[k[1:0]] = rx_word;
      end
      if (len_setting == `LEN_VARIABLE) begin
        last = rx_last;
      end else begin
        last = ({4'h0, k} + 7'h01) == len_setting;
      end
      n.cnt = (k < 3'h6) ? k + 3'h1 : 3'h6;
      if (last) begin
        n.pend = 1'b1;
        n.nw = (k >= 3'h3) ? 3'h4 : k + 3'h1;
        n.cnt = 3'h7;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '{cnt: 3'h7, w: '0, pend: 1'b0, nw: 3'h0};
    end else begin
      r <= n;
    end
  end

  assign rx_ready = !r.pend;
  assign chan.req_valid = r.pend;
  assign chan.req_ident = r.w[0];
  assign chan.req_index = r.w[1];
  assign chan.req_value = {r.w[2], r.w[3]};
  assign chan.req_nwords = r.nw;
endmodule : param_word_rx

// ---- design/param_word_tx.sv ----
// Sends reply words in ascending order with a registered output stage.
module param_word_tx (
  input wire logic hclk,
  input wire logic hresetn,
  output logic tx_valid,
  output logic tx_first,
  output logic tx_last,
  output spc_pkg::word_t tx_word,
  input wire logic tx_ready,
  spc_chan_if.tx chan
);
  import spc_pkg::*;
  typedef struct packed {
    logic act;
    logic [6:0] idx;
    logic [6:0] len;
    logic ov;
    logic of;
    logic ol;
    word_t w;
    logic done;
  } tx_state_t;
  tx_state_t r, n;

  always_comb begin
    n = r;
    n.done = 1'b0;
    if (r.ov && tx_ready) begin
      n.ov = 1'b0;
    end
    if (chan.rsp_start) begin
      n.act = 1'b1;
      n.idx = 7'h00;
      n.len = chan.rsp_len;
    end else if (r.act && (!r.ov || tx_ready)) begin
      n.ov = 1'b1;
      n.w = chan.rsp_word;
      n.of = r.idx == 7'h00;
      n.ol = r.idx == r.len - 7'h01;
      n.idx = r.idx + 7'h01;
      if (n.ol) begin
        n.act = 1'b0;
        n.done = 1'b1;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign chan.rsp_idx = r.idx;
  assign chan.rsp_done = r.done;
  assign tx_valid = r.ov;
  assign tx_first = r.of;
  assign tx_last = r.ol;
  assign tx_word = r.w;
endmodule : param_word_tx

// ---- design/serial_parameter_channel.sv ----
// Parameter channel executor with its AHB-Lite register slave and parameter store.
//
// Chosen here: the AHB-Lite slave port and the register addresses.
`include "spc_defines.svh"
// Contract
// - Length setting is 3, 4 or 127.
// - 16-bit access: identifier, index, one value.
// - 32-bit access: identifier, index, two values.
// - Variable mode reply length may differ.
// - Value words between 1 and 118 or 126.
// - Variable replies send needed words, minimum three.
// - Variable: 16-bit reply 3, 32-bit reply 4.
// - Index 255 read-all only in variable mode.
// - Length set at start-up, frozen while operating.
// - Words go in ascending order, identifier first.
// - Bits 12 to 15 carry task/reply code.
// - Change-report toggle bit is always zero.
// - Text-access flag unsupported, always zero.
// - Read tasks map to replies 1-6, fail 7.
// - Volatile writes 2,3,7,8 reply 1,2,4,5.
// - Stored writes 14,13,12,11 reply 1,2,4,5.
// - Task 10 reserved; tasks 5, 15 unsupported.
// - Index word selects element or description.
// - Reply code in task position, permitted only.
// - Reply 7 carries fault in second value; with length setting 3 the code puts it in the first value word.
// - Reply 8 means no master authority.
module serial_parameter_channel #(
  parameter int PARAM_COUNT = 16,
  parameter int ARRAY_LEN = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_valid,
  input wire logic rx_first,
  input wire logic rx_last,
  input wire spc_pkg::word_t rx_word,
  output logic rx_ready,
  output logic tx_valid,
  output logic tx_first,
  output logic tx_last,
  output spc_pkg::word_t tx_word,
  input wire logic tx_ready,
  input wire logic bus_active,
  input wire logic process_data_present,
  output logic nv_write,
  output logic [$clog2(PARAM_COUNT*ARRAY_LEN)-1:0] nv_addr,
  output logic [31:0] nv_data
);
  import spc_pkg::*;
  localparam int PW = $clog2(PARAM_COUNT);
  localparam int EW = $clog2(ARRAY_LEN);
  localparam int AW = PW + EW;
  localparam logic [6:0] ALEN = 7'(ARRAY_LEN);

  typedef struct packed {
    exec_state_t st;
    logic aw_pend;
    logic [7:0] aw_addr;
    logic [31:0] rdata;
    logic [6:0] len_set;
    logic auth;
    logic [PARAM_COUNT-1:0] dmask;
    logic [PARAM_COUNT-1:0] amask;
    logic [AW-1:0] maddr;
    logic [31:0] tcount;
    code_t last_task;
    code_t last_reply;
    logic [7:0] last_fault;
    code_t code;
    logic all;
    logic dw;
    logic [6:0] rlen;
    logic [10:0] parameter_number;
    word_t index;
    logic [31:0] val;
    logic start;
    logic nv_w;
    logic [AW-1:0] nv_a;
    logic [31:0] nv_d;
    logic ex_we;
    logic sw_we;
    logic [AW-1:0] ex_a;
    logic [31:0] ex_d;
    logic [31:0] sw_d;
  } state_t;

  state_t r, n;
  logic [31:0] mem [0:PARAM_COUNT*ARRAY_LEN-1];
  spc_chan_if chan ();

  param_word_rx u_rx (
    .hclk(hclk),
    .hresetn(hresetn),
    .rx_valid(rx_valid),
    .rx_first(rx_first),
    .rx_last(rx_last),
    .rx_word(rx_word),
    .rx_ready(rx_ready),
    .len_setting(r.len_set),
    .chan(chan)
  );

  param_word_tx u_tx (
    .hclk(hclk),
    .hresetn(hresetn),
    .tx_valid(tx_valid),
    .tx_first(tx_first),
    .tx_last(tx_last),
    .tx_word(tx_word),
    .tx_ready(tx_ready),
    .chan(chan)
  );

  // Reply word k, built on demand so read-all replies need no buffer.
  function automatic word_t reply_word(input logic [6:0] k);
    logic [6:0] j;
    logic [AW-1:0] ea;
    logic [31:0] ev;
    j = k - 7'h02;
    ea = r.dw ? {r.parameter_number[PW-1:0], j[EW:1]} : {r.parameter_number[PW-1:0], j[EW-1:0]};
    ev = mem[ea];
    reply_word = 16'h0000;
    if (k == 7'h00) begin
      reply_word = {r.code, 1'b0, r.parameter_number};
    end else if (k == 7'h01) begin
      reply_word = r.index & 16'h7FFF;
    end else if (r.code == `REPLY_FAIL) begin
      if (r.rlen == `LEN_FIXED3 ? k == 7'h02 : k == 7'h03) begin
        reply_word = r.val[15:0];
      end
    end else if (r.all) begin
      if (r.dw) begin
        reply_word = j[0] ? ev[15:0] : ev[31:16];
      end else begin
        reply_word = ev[15:0];
      end
    end else if (r.dw) begin
      if (k == 7'h02) begin
        reply_word = r.val[31:16];
      end else if (k == 7'h03) begin
        reply_word = r.val[15:0];
      end
    end else if (k == 7'h02) begin
      reply_word = r.val[15:0];
    end
  endfunction : reply_word

  always_comb begin
    code_t t;
    code_t code;
    logic [7:0] flt;
    logic [7:0] el;
    logic [PW-1:0] pi;
    logic pv;
    logic dw;
    logic ar;
    logic vmode;
    logic wr;
    logic arr_el;
    logic all;
    logic want_dw;
    logic want_w;
    logic [31:0] wv;
    logic [31:0] rv;
    logic [6:0] vlen;
    logic [7:0] lmax;
    n = r;
    n.start = 1'b0;
    n.nv_w = 1'b0;
    n.ex_we = 1'b0;
    n.sw_we = 1'b0;
    t = chan.req_ident[15:12];
    el = chan.req_index[7:0];
    pi = chan.req_ident[PW-1:0];
    pv = {5'h00, chan.req_ident[10:0]} < 16'(PARAM_COUNT);
    dw = r.dmask[pi];
    ar = r.amask[pi];
    vmode = r.len_set == `LEN_VARIABLE;
    all = el == `INDEX_ALL;
    wr = t inside {`TASK_W_RAM, `TASK_DW_RAM, `TASK_DESC_WR, `TASK_ARR_W_RAM, `TASK_ARR_DW_RAM,
                   `TASK_ARR_DW_NV, `TASK_ARR_W_NV, `TASK_DW_NV, `TASK_W_NV, `TASK_TEXT};
    arr_el = t inside {`TASK_ARR_RD, `TASK_ARR_W_RAM, `TASK_ARR_DW_RAM, `TASK_ARR_DW_NV, `TASK_ARR_W_NV};
    want_dw = t inside {`TASK_DW_RAM, `TASK_ARR_DW_RAM, `TASK_ARR_DW_NV, `TASK_DW_NV};
    want_w = t inside {`TASK_W_RAM, `TASK_ARR_W_RAM, `TASK_ARR_W_NV, `TASK_W_NV};
    wv = dw ? chan.req_value : {16'h0000, chan.req_value[31:16]};
    rv = mem[{pi, arr_el ? el[EW-1:0] : {EW{1'b0}}}];
    code = `REPLY_FAIL;
    flt = `FAULT_STATE;
    vlen = 7'h03;
    lmax = 8'h02 + {1'b0, (process_data_present ? `MAX_VALUES_PZD : `MAX_VALUES_NOPZD)};

    // AHB data phase: writes other than REG_MEM_DATA land before the next read is sampled.
    if (r.aw_pend) begin
      if (r.aw_addr == `REG_CTRL) begin
        // only 3, 4 or 127 accepted.
        if (!bus_active && hwdata[6:0] inside {`LEN_FIXED3, `LEN_FIXED4, `LEN_VARIABLE}) begin
          n.len_set = hwdata[6:0];
        end
        n.auth = hwdata[`CTRL_AUTH_BIT];
      end else if (r.aw_addr == `REG_DWORD_MASK) begin
        n.dmask = hwdata[PARAM_COUNT-1:0];
      end else if (r.aw_addr == `REG_ARRAY_MASK) begin
        n.amask = hwdata[PARAM_COUNT-1:0];
      end else if (r.aw_addr == `REG_MEM_ADDR) begin
        n.maddr = hwdata[AW-1:0];
      end else if (r.aw_addr == `REG_MEM_DATA) begin
        n.sw_we = 1'b1;
        n.sw_d = hwdata;
      end
    end

    if (r.st == ST_IDLE && chan.req_valid) begin
      n.val = 32'h0000_0000;
      n.all = 1'b0;
      n.dw = 1'b0;
      if (t == `TASK_NONE) begin
        code = `REPLY_NONE;
      end else if (chan.req_index[`TEXT_FLAG_BIT] || t == `TASK_TEXT) begin
        flt = `FAULT_NO_TEXT;
      end else if (t == `TASK_RESERVED) begin
        flt = `FAULT_STATE;
      end else if (wr && !r.auth) begin
        code = `REPLY_NO_AUTH;
      end else if (!pv) begin
        flt = `FAULT_PNU;
      end else if (t == `TASK_DESC_WR) begin
        flt = `FAULT_DESC_RO;
      end else if ((arr_el || t == `TASK_ARR_COUNT) && !ar) begin
        flt = `FAULT_NO_ARRAY;
      end else if (arr_el && all && !(t == `TASK_ARR_RD && vmode)) begin
        flt = `FAULT_SUBINDEX;
      end else if (arr_el && !all && {1'b0, el} >= 9'(ARRAY_LEN)) begin
        flt = `FAULT_SUBINDEX;
      end else if ((want_dw && (!dw || chan.req_nwords < 3'h4)) || (want_w && dw)) begin
        flt = `FAULT_TYPE;
      end else begin
        case (t)
          `TASK_READ: begin
            code = dw ? `REPLY_DWORD : `REPLY_WORD;
            n.val = rv;
          end
          `TASK_W_RAM, `TASK_W_NV: code = `REPLY_WORD;
          `TASK_DW_RAM, `TASK_DW_NV: code = `REPLY_DWORD;
          `TASK_DESC_RD: begin
            if (el == 8'h00) begin
              code = `REPLY_DESC;
              n.val = {30'h0000_0000, ar, dw};
            end else if (el == 8'h01) begin
              code = `REPLY_DESC;
              n.val = 32'(ARRAY_LEN);
            end else begin
              flt = `FAULT_SUBINDEX;
            end
          end
          `TASK_ARR_RD: begin
            code = dw ? `REPLY_ARR_DWORD : `REPLY_ARR_WORD;
            n.all = all;
            n.val = rv;
          end
          `TASK_ARR_W_RAM, `TASK_ARR_W_NV: code = `REPLY_ARR_WORD;
          `TASK_ARR_DW_RAM, `TASK_ARR_DW_NV: code = `REPLY_ARR_DWORD;
          `TASK_ARR_COUNT: begin
            code = `REPLY_COUNT;
            n.val = 32'(ARRAY_LEN);
          end
          default: code = `REPLY_FAIL;
        endcase
        if (wr && code != `REPLY_FAIL) begin
          n.ex_we = 1'b1;
          n.ex_a = {pi, arr_el ? el[EW-1:0] : {EW{1'b0}}};
          n.ex_d = wv;
          n.val = wv;
          n.nv_w = t inside {`TASK_ARR_DW_NV, `TASK_ARR_W_NV, `TASK_DW_NV, `TASK_W_NV};
          n.nv_a = n.ex_a;
          n.nv_d = wv;
        end
      end
      n.dw = code inside {`REPLY_DWORD, `REPLY_ARR_DWORD};
      if (code == `REPLY_FAIL) begin
        n.val = {24'h00_0000, flt};
      end
      // 3 words for 16-bit, 4 for 32-bit.
      // only needed words, never under three.
      if (code == `REPLY_FAIL || n.dw) begin
        vlen = 7'h04;
      end
      if (n.all) begin
        vlen = 7'h02 + (n.dw ? ALEN + ALEN : ALEN);
      end
      // value words capped by process data.
      if ({1'b0, vlen} > lmax) begin
        vlen = lmax[6:0];
      end
      n.rlen = vmode ? vlen : r.len_set;
      n.code = code;
      n.parameter_number = chan.req_ident[10:0];
      n.index = chan.req_index;
      n.last_task = t;
      n.last_reply = code;
      n.last_fault = (code == `REPLY_FAIL) ? flt : 8'h00;
      n.tcount = r.tcount + 32'h0000_0001;
      n.start = 1'b1;
      n.st = ST_SEND;
    end else if (r.st == ST_SEND && chan.rsp_done) begin
      n.st = ST_IDLE;
    end

    // AHB address phase: sample the request, read data from the updated copy.
    n.aw_pend = 1'b0;
    if (hsel && hready && htrans[1]) begin
      if (hwrite) begin
        n.aw_pend = 1'b1;
        n.aw_addr = haddr[7:0];
      end else if (haddr[7:0] == `REG_CTRL) begin
        n.rdata = {23'h00_0000, n.auth, 1'b0, n.len_set};
      end else if (haddr[7:0] == `REG_STATUS) begin
        n.rdata = {14'h0000, bus_active, r.st == ST_SEND, n.last_fault, n.last_reply, n.last_task};
      end else if (haddr[7:0] == `REG_DWORD_MASK) begin
        n.rdata = 32'(n.dmask);
      end else if (haddr[7:0] == `REG_ARRAY_MASK) begin
        n.rdata = 32'(n.amask);
      end else if (haddr[7:0] == `REG_MEM_ADDR) begin
        n.rdata = 32'(n.maddr);
      end else if (haddr[7:0] == `REG_MEM_DATA) begin
        n.rdata = r.sw_we && !(r.ex_we && r.ex_a == r.maddr) && n.maddr == r.maddr ? r.sw_d : mem[n.maddr];
      end else if (haddr[7:0] == `REG_TASK_COUNT) begin
        n.rdata = n.tcount;
      end else begin
        n.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r <= '0;
      r.len_set <= `LEN_FIXED3;
      r.auth <= `CTRL_AUTH_RESET;
    end else begin
      r <= n;
    end
  end

  // The parameter store is not reset; software loads it before the link runs.
  // A software write that meets an executor write to the same word loses to it.
  always_ff @(posedge hclk) begin
    if (r.sw_we) begin
      mem[r.maddr] <= r.sw_d;
    end
    if (r.ex_we) begin
      mem[r.ex_a] <= r.ex_d;
    end
  end

  assign chan.req_ready = r.st == ST_IDLE;
  assign chan.rsp_start = r.start;
  assign chan.rsp_len = r.rlen;
  // A process, not an assign, so changes of the executor state inside the function are seen.
  always_comb chan.rsp_word = reply_word(chan.rsp_idx);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = r.rdata;
  assign nv_write = r.nv_w;
  assign nv_addr = r.nv_a;
  assign nv_data = r.nv_d;
endmodule : serial_parameter_channel

// ---- sim/spc_checker.sv ----
// Checker for the reply stream and store pulse of the parameter channel.
module spc_checker (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire spc_pkg::word_t tx_word,
  input wire logic tx_ready,
  input wire logic nv_write
);
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  logic [7:0] cnt_r;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Counts accepted words of the reply under way, so length rules can be judged at the last word.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= 8'h00;
    end else if (tx_valid && tx_ready) begin
      cnt_r <= tx_first ? 8'h01 : cnt_r + 8'h01;
    end
  end
  toggle_zero_a: assert property (tx_valid && tx_first |-> !tx_word[11])
    else $error("toggle bit set in reply");
  reply_code_a: assert property (tx_valid && tx_first |-> tx_word[15:12] <= 4'h8)
    else $error("reply code out of range");
  word_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_word) && $stable(tx_last))
    else $error("reply word changed while stalled");
  first_once_a: assert property (tx_valid && tx_ready && tx_first && !tx_last |=> !tx_first)
    else $error("first flag repeated");
  min_words_a: assert property (tx_valid && tx_last |-> !tx_first && cnt_r >= 8'h02)
    else $error("reply shorter than three words");
  text_flag_a: assert property (tx_valid && !tx_first && cnt_r == 8'h01 |-> !tx_word[15])
    else $error("text flag set in index echo");
  nv_pulse_a: assert property (nv_write |=> !nv_write)
    else $error("store pulse too long");
  nv_reply_a: assert property (nv_write |-> ##[0:6] (tx_valid && tx_first && tx_word[15:12] inside {4'h1, 4'h2, 4'h4, 4'h5}))
    else $error("store without positive reply");
endmodule : spc_checker

// ---- sim/spc_master_model.sv ----
// Behavioural controller that sends parameter requests and gathers replies.
module spc_master_model (
  input wire logic hclk,
  output logic rx_valid,
  output logic rx_first,
  output logic rx_last,
  output spc_pkg::word_t rx_word,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic tx_first,
  input wire logic tx_last,
  input wire spc_pkg::word_t tx_word,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  logic slow = 1'b0;
  int ph = 0;
  int frames = 0;
  int stalls = 0;
  word_t rq[$];
  initial begin
    rx_valid = 1'b0;
    rx_first = 1'b0;
    rx_last = 1'b0;
    rx_word = 16'h0000;
    tx_ready = 1'b0;
  end
  // words of the latest reply kept in order; a slow master takes one word in three.
  always @(posedge hclk) begin
    ph <= ph + 1;
    tx_ready <= !slow || (ph % 3 == 0);
    if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
      if (tx_first === 1'b1) rq.delete();
      rq.push_back(tx_word);
      if (tx_last === 1'b1) frames++;
    end
  end
  // words ascending from the identifier, reserved bits zero.
  task automatic send(input word_t w[4], input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_first <= (i == 0);
      rx_last <= (i == n - 1);
      rx_word <= w[i];
      k = 0;
      do begin
        @(posedge hclk);
        k++;
      end while (rx_ready !== 1'b1 && k < 100);
      if (rx_ready !== 1'b1) stalls++;
    end
    rx_valid <= 1'b0;
    rx_first <= 1'b0;
    rx_last <= 1'b0;
    // A released word line shows the inverse so a stale value is never mistaken for data.
    rx_word <= ~w[n - 1];
  endtask : send
endmodule : spc_master_model

// ---- sim/serial_parameter_channel_tb.sv ----
// Self-checking bench for the parameter channel over its register bus and word stream.
`include "spc_defines.svh"
module serial_parameter_channel_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import spc_pkg::*;
  localparam logic [31:0] all_m = 32'hFFFFFFFF;
  localparam logic [31:0] lo_m = 32'h0000FFFF;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic bus_active = 1'b0;
  logic process_data_present = 1'b0;
  logic hreadyout, hresp, rx_valid, rx_first, rx_last, rx_ready, tx_valid, tx_first, tx_last, tx_ready, nv_write;
  logic [31:0] hrdata, nv_data, q;
  logic [5:0] nv_addr;
  word_t rx_word, tx_word;
  logic [31:0] md [6] = '{32'h1234, 32'hAABBCCDD, 32'h100, 32'h101, 32'h102, 32'h103};
  int miscompares = 0;
  int check_count = 0;
  int nv_cnt = 0;
  always #50 hclk = ~hclk;
  serial_parameter_channel dut (
    .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .rx_valid, .rx_first, .rx_last, .rx_word, .rx_ready, .tx_valid, .tx_first, .tx_last,
    .tx_word, .tx_ready, .bus_active, .process_data_present, .nv_write, .nv_addr, .nv_data
  );
  spc_master_model mm (.hclk, .rx_valid, .rx_first, .rx_last, .rx_word, .rx_ready, .tx_valid, .tx_first,
    .tx_last, .tx_word, .tx_ready);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask : chk
  task end_sim;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  always @(posedge hclk) begin
    if (nv_write === 1'b1) begin
      nv_cnt++;
      chk(nv_data, 32'h11223344, "store data");
      chk({26'h0, nv_addr}, 32'h4, "store address");
    end
  end
  task automatic wt;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1) begin
      chk(32'h0, 32'h1, "bus timeout");
      end_sim;
    end
  endtask : wt
  // Caller stands just after a rising edge; each phase is held until hready is sampled high.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wt;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wt;
    q = hrdata;
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(q, exp, m);
  endtask : rd
  task automatic req(input code_t t, input logic [10:0] p, input word_t ix, input logic [31:0] v, input int n,
                     input int rn, input code_t rc, input logic [31:0] rv, input logic [31:0] mk);
    word_t w[4];
    int f;
    int k;
    logic [31:0] got;
    w[0] = {t, 1'b0, p};
    w[1] = ix;
    w[2] = v[31:16];
    w[3] = v[15:0];
    f = mm.frames;
    k = 0;
    mm.send(w, n);
    while (mm.frames == f && k < 400) begin
      @(posedge hclk);
      k++;
    end
    if (mm.frames == f) begin
      chk(32'h0, 32'h1, "reply timeout");
      end_sim;
    end
    got = {mm.rq[2], (rn > 3) ? mm.rq[3] : 16'h0000};
    chk(32'(mm.rq.size()), rn, "reply length");
    chk({16'h0, mm.rq[0]}, {16'h0, rc, 1'b0, p}, "reply identifier");
    chk({16'h0, mm.rq[1]}, {16'h0, ix & 16'h7FFF}, "index echo");
    chk(got & mk, rv & mk, "reply value");
  endtask : req
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`REG_CTRL, 32'h103, "control reset");
    chk({30'h0, hreadyout, hresp}, 32'h2, "bus response");
    bus(1'b1, `REG_DWORD_MASK, 32'h2);
    bus(1'b1, `REG_ARRAY_MASK, 32'h4);
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, `REG_MEM_ADDR, (i < 2) ? 32'(4 * i) : 32'(6 + i));
      bus(1'b1, `REG_MEM_DATA, md[i]);
    end
    rd(`REG_MEM_DATA, 32'h103, "store readback");
    rd(8'h1C, 32'h0, "unmapped read");
    req(`TASK_READ, 11'd0, 16'h0, 32'h0, 3, 3, `REPLY_WORD, 32'h12340000, all_m);
    req(`TASK_ARR_RD, 11'd2, 16'h2, 32'h0, 3, 3, `REPLY_ARR_WORD, 32'h01020000, all_m);
    req(`TASK_NONE, 11'd0, 16'h0, 32'h0, 3, 3, `REPLY_NONE, 32'h0, 32'h0);
    bus(1'b1, `REG_CTRL, 32'h104);
    req(`TASK_READ, 11'd1, 16'h0, 32'h0, 4, 4, `REPLY_DWORD, 32'hAABBCCDD, all_m);
    req(`TASK_W_RAM, 11'd0, 16'h0, 32'h55550000, 4, 4, `REPLY_WORD, 32'h55550000, all_m);
    req(`TASK_READ, 11'd0, 16'h0, 32'h0, 4, 4, `REPLY_WORD, 32'h55550000, all_m);
    req(`TASK_DW_NV, 11'd1, 16'h0, 32'h11223344, 4, 4, `REPLY_DWORD, 32'h11223344, all_m);
    req(`TASK_RESERVED, 11'd0, 16'h0, 32'h0, 4, 4, `REPLY_FAIL, {24'h0, `FAULT_STATE}, lo_m);
    req(`TASK_TEXT, 11'd0, 16'h0, 32'h0, 4, 4, `REPLY_FAIL, {24'h0, `FAULT_NO_TEXT}, lo_m);
    req(`TASK_ARR_RD, 11'd2, 16'hFF, 32'h0, 4, 4, `REPLY_FAIL, {24'h0, `FAULT_SUBINDEX}, lo_m);
    bus(1'b0, `REG_STATUS, 32'h0);
    chk({24'h0, q[7:0]}, 32'h76, "status codes");
    bus(1'b1, `REG_CTRL, 32'h004);
    req(`TASK_W_RAM, 11'd0, 16'h0, 32'h66660000, 4, 4, `REPLY_NO_AUTH, 32'h0, 32'h0);
    req(`TASK_READ, 11'd0, 16'h0, 32'h0, 4, 4, `REPLY_WORD, 32'h55550000, all_m);
    bus_active <= 1'b1;
    bus(1'b1, `REG_CTRL, 32'h17F);
    rd(`REG_CTRL, 32'h104, "length frozen");
    bus_active <= 1'b0;
    bus(1'b1, `REG_CTRL, 32'h105);
    rd(`REG_CTRL, 32'h104, "length refused");
    bus(1'b1, `REG_CTRL, 32'h17F);
    req(`TASK_READ, 11'd0, 16'h0, 32'h0, 4, 3, `REPLY_WORD, 32'h55550000, all_m);
    req(`TASK_READ, 11'd1, 16'h0, 32'h0, 3, 4, `REPLY_DWORD, 32'h11223344, all_m);
    req(`TASK_DESC_RD, 11'd2, 16'h1, 32'h0, 3, 3, `REPLY_DESC, 32'h00040000, all_m);
    req(`TASK_ARR_COUNT, 11'd2, 16'h0, 32'h0, 3, 3, `REPLY_COUNT, 32'h00040000, all_m);
    req(`TASK_DESC_WR, 11'd2, 16'h0, 32'h0, 3, 4, `REPLY_FAIL, {24'h0, `FAULT_DESC_RO}, lo_m);
    mm.slow <= 1'b1;
    req(`TASK_ARR_RD, 11'd2, 16'hFF, 32'h0, 3, 6, `REPLY_ARR_WORD, 32'h01000101, all_m);
    mm.slow <= 1'b0;
    chk(32'(nv_cnt), 32'h1, "store pulse count");
    chk(32'(mm.stalls), 32'h0, "word stall");
    rd(`REG_TASK_COUNT, 32'h12, "task count");
    end_sim;
  end
endmodule : serial_parameter_channel_tb
bind serial_parameter_channel spc_checker chk_i (.hclk, .hresetn, .tx_valid, .tx_first, .tx_last, .tx_word,
  .tx_ready, .nv_write);
